// >>> design/tpc_pkg.sv
package tpc_pkg;

   // ----------------------------------------------------------------
   // Bus and register map
   // ----------------------------------------------------------------
   localparam int               ADDR_W      = 8;
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CMPA   = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CMPP   = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
   localparam logic [1:0]       RESP_OKAY   = 2'h0;
   localparam logic [1:0]       RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Control word fields
   // ----------------------------------------------------------------
   localparam int               CTRL_W      = 12;
   localparam int               B_RUN       = 0;
   localparam int               B_MODE      = 1;
   localparam int               B_PIO       = 3;
   localparam int               B_OC        = 5;
   localparam int               B_INV       = 6;
   localparam int               B_CCLR      = 7;
   localparam int               B_SWAP      = 8;
   localparam int               B_EXT_FALL  = 9;
   localparam int               B_DIV       = 10;
   localparam logic [CTRL_W-1:0] CTRL_RST   = 12'h000;
   localparam int               ST_A        = 0;
   localparam int               ST_P        = 1;

   // ----------------------------------------------------------------
   // Counter and codes
   // ----------------------------------------------------------------
   localparam int               CNT_W       = 16;
   localparam int               CMPP_W      = 8;
   localparam int               PRE_W       = 6;
   localparam logic [CNT_W-1:0] CNT_ZERO    = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE     = 16'h0001;
   localparam logic [7:0]       LOW_ZERO    = 8'h00;
   localparam logic [CMPP_W-1:0] CMPP_ZERO  = 8'h00;
   localparam logic [PRE_W-1:0] DIV_M1      = 6'h00;
   localparam logic [PRE_W-1:0] DIV_M4      = 6'h03;
   localparam logic [PRE_W-1:0] DIV_M16     = 6'h0F;
   localparam logic [PRE_W-1:0] DIV_M64     = 6'h3F;

   typedef enum logic [1:0] {
      MODE_CMP = 2'h0,
      MODE_CAP = 2'h1,
      MODE_PWM = 2'h2,
      MODE_TMR = 2'h3
   } tpc_mode_t;

   localparam logic [1:0]       PIO_INACT   = 2'h0;
   localparam logic [1:0]       PIO_ACT     = 2'h1;
   localparam logic [1:0]       PIO_PWM     = 2'h2;
   localparam logic [1:0]       PIO_PULSE   = 2'h3;
   localparam logic [1:0]       CAP_RISE    = 2'h0;
   localparam logic [1:0]       CAP_FALL    = 2'h1;
   localparam logic [1:0]       CAP_BOTH    = 2'h2;
   localparam logic [1:0]       CAP_OFF     = 2'h3;

   typedef struct packed {
      logic [PRE_W-1:0]  presc;
      logic [CTRL_W-1:0] ctrl;
      logic              run_d;
      logic [CNT_W-1:0]  cnt;
      logic [CNT_W-1:0]  cmpa;
      logic [CMPP_W-1:0] cmpp;
      logic              flag_a;
      logic              flag_p;
      logic              pin_s1;
      logic              pin_s2;
      logic              pin_prev;
      logic              ext_s1;
      logic              ext_s2;
      logic              ext_prev;
      logic              pin_out;
      logic              pin_oe_n;
      logic              aw_got;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_got;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              aw_rdy;
      logic              w_rdy;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              ar_rdy;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
   } tpc_state_t;

endpackage

// >>> design/tpc_timer.sv
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module tpc_timer
(
   // Clock and reset
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   // Write address and data
   input  wire logic [tpc_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic [2:0]                  s_axi_awprot,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   // Write response
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   // Read
   input  wire logic [tpc_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic [2:0]                  s_axi_arprot,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   // Timer pins
   input  wire logic                        ext_clock_pin,
   input  wire logic                        timer_io_pin_in,
   output logic                             timer_io_pin_out,
   output logic                             timer_io_pin_oe_n
);
   import tpc_pkg::*;

   // ----------------------------------------------------------------
   // State and decoded fields
   // ----------------------------------------------------------------
   tpc_state_t       s;
   tpc_state_t       next_s;
   logic [31:0]      strb_mask;
   tpc_mode_t        mode;
   logic [1:0]       pio;
   logic             run_rise;
   logic             tick;
   logic [CNT_W-1:0] inc;
   logic [CNT_W-1:0] cmpp_full;
   logic             a_hit;
   logic             p_hit;
   logic             is_pwm;
   logic             is_pulse;
   logic             is_cap;
   logic             cap_edge;
   logic             ext_edge;
   logic             duty_full;
   logic             pwm_active;
   logic             act_lvl;
   logic             do_wr;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_strb
         assign strb_mask[8*gi +: 8] = {8{s.wstrb[gi]}};
      end
   endgenerate

   assign mode      = tpc_mode_t'(s.ctrl[B_MODE +: 2]);
   assign pio       = s.ctrl[B_PIO +: 2];
   assign run_rise  = s.ctrl[B_RUN] && !s.run_d;
   assign inc       = s.cnt + CNT_ONE;
   assign cmpp_full = {s.cmpp, LOW_ZERO};
   assign a_hit     = (inc == s.cmpa);
   assign p_hit     = (inc == cmpp_full);
   assign is_pwm    = (mode == MODE_PWM) && (pio != PIO_PULSE);
   assign is_pulse  = (mode == MODE_PWM) && (pio == PIO_PULSE);
   assign is_cap    = (mode == MODE_CAP);
   assign act_lvl   = s.ctrl[B_OC] ^ s.ctrl[B_INV];
   assign do_wr     = s.aw_got && s.w_got && !s.bvalid;
   assign ext_edge  = s.ctrl[B_EXT_FALL] ? (s.ext_prev && !s.ext_s2)
                                         : (!s.ext_prev && s.ext_s2);

   // ----------------------------------------------------------------
   // Tick prescaler select
   // ----------------------------------------------------------------
   always_comb
   begin
      unique case (s.ctrl[B_DIV +: 2])
         2'h0: tick = ((s.presc & DIV_M1) == DIV_M1);
         2'h1: tick = ((s.presc & DIV_M4) == DIV_M4);
         2'h2: tick = ((s.presc & DIV_M16) == DIV_M16);
         2'h3: tick = ((s.presc & DIV_M64) == DIV_M64);
      endcase
   end

   // ----------------------------------------------------------------
   // Capture edge select and PWM duty
   // ----------------------------------------------------------------
   always_comb
   begin
      unique case (pio)
         CAP_RISE: cap_edge = !s.pin_prev && s.pin_s2;
         CAP_FALL: cap_edge = s.pin_prev && !s.pin_s2;
         CAP_BOTH: cap_edge = s.pin_prev != s.pin_s2;
         CAP_OFF:  cap_edge = 1'b0;
      endcase
      if (s.ctrl[B_SWAP])
      begin
         duty_full  = (s.cmpp == CMPP_ZERO) ||
                      ((s.cmpa != CNT_ZERO) && (cmpp_full >= s.cmpa));
         pwm_active = duty_full || (s.cnt < cmpp_full);
      end
      else
      begin
         duty_full  = (s.cmpp != CMPP_ZERO) && (s.cmpa >= cmpp_full);
         pwm_active = duty_full || (s.cnt < s.cmpa);
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic clr;
      logic set_a;
      logic set_p;
      logic [31:0] merged;
      logic [31:0] old_word;
      clr      = 1'b0;
      set_a    = 1'b0;
      set_p    = 1'b0;
      merged   = '0;
      old_word = '0;
      next_s   = s;

      next_s.presc    = s.presc + {{(PRE_W-1){1'b0}}, 1'b1};
      next_s.pin_s1   = timer_io_pin_in;
      next_s.pin_s2   = s.pin_s1;
      next_s.pin_prev = s.pin_s2;
      next_s.ext_s1   = ext_clock_pin;
      next_s.ext_s2   = s.ext_s1;
      next_s.ext_prev = s.ext_s2;
      next_s.run_d    = s.ctrl[B_RUN];

      // Write channel
      if (s_axi_awvalid && s.aw_rdy)
      begin
         next_s.aw_got  = 1'b1;
         next_s.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.w_rdy)
      begin
         next_s.w_got = 1'b1;
         next_s.wdata = s_axi_wdata;
         next_s.wstrb = s_axi_wstrb;
      end
      if (s.bvalid && s_axi_bready)
         next_s.bvalid = 1'b0;

      unique case (s.aw_addr)
         OFS_CTRL:   old_word = {{(32-CTRL_W){1'b0}}, s.ctrl};
         OFS_CMPA:   old_word = {{(32-CNT_W){1'b0}}, s.cmpa};
         OFS_CMPP:   old_word = {{(32-CMPP_W){1'b0}}, s.cmpp};
         default:    old_word = '0;
      endcase
      merged = (old_word & ~strb_mask) | (s.wdata & strb_mask);

      if (do_wr)
      begin
         next_s.aw_got = 1'b0;
         next_s.w_got  = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp  = RESP_OKAY;
         unique case (s.aw_addr)
            OFS_CTRL:   next_s.ctrl = merged[CTRL_W-1:0];
            OFS_CMPA:   next_s.cmpa = merged[CNT_W-1:0];
            OFS_CMPP:   next_s.cmpp = merged[CMPP_W-1:0];
            OFS_COUNT:  ;
            OFS_STATUS: ;
            default:    next_s.bresp = RESP_SLVERR;
         endcase
      end

      // Timer core
      if (run_rise)
         next_s.cnt = CNT_ZERO;
      else if (s.ctrl[B_RUN] && tick)
      begin
         if (is_pulse)
         begin
            if (a_hit)
            begin
               next_s.ctrl[B_RUN] = 1'b0;
               set_a = 1'b1;
            end
         end
         else if (is_pwm)
         begin
            clr   = s.ctrl[B_SWAP] ? a_hit : p_hit;
            set_a = a_hit;
            set_p = p_hit;
         end
         else if (is_cap)
         begin
            clr   = p_hit;
            set_p = p_hit;
         end
         else
         begin
            clr   = s.ctrl[B_CCLR] ? a_hit : p_hit;
            set_a = a_hit;
            set_p = p_hit && !s.ctrl[B_CCLR];
         end
         next_s.cnt = clr ? CNT_ZERO : inc;
      end

      if (is_pulse && ext_edge)
         next_s.ctrl[B_RUN] = 1'b1;

      if (is_cap && cap_edge)
      begin
         next_s.cmpa = s.cnt;
         set_a = 1'b1;
      end

      // Sticky flags, write one to clear, set wins
      next_s.flag_a = (s.flag_a && !(do_wr && s.aw_addr == OFS_STATUS &&
                       s.wstrb[0] && s.wdata[ST_A])) || set_a;
      next_s.flag_p = (s.flag_p && !(do_wr && s.aw_addr == OFS_STATUS &&
                       s.wstrb[0] && s.wdata[ST_P])) || set_p;

      // Pin drive
      next_s.pin_oe_n = 1'b1;
      next_s.pin_out  = 1'b0;
      if (mode == MODE_PWM)
      begin
         next_s.pin_oe_n = 1'b0;
         unique case (pio)
            PIO_INACT: next_s.pin_out = !act_lvl;
            PIO_ACT:   next_s.pin_out = act_lvl;
            PIO_PWM:   next_s.pin_out = (pwm_active && !run_rise) ?
                                        act_lvl : !act_lvl;
            PIO_PULSE: next_s.pin_out = s.ctrl[B_RUN] ?
                                        act_lvl : !act_lvl;
         endcase
      end

      // Read channel
      if (s.rvalid && s_axi_rready)
         next_s.rvalid = 1'b0;
      if (s_axi_arvalid && s.ar_rdy)
      begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = RESP_OKAY;
         unique case (s_axi_araddr)
            OFS_CTRL:   next_s.rdata = {{(32-CTRL_W){1'b0}}, s.ctrl};
            OFS_CMPA:   next_s.rdata = {{(32-CNT_W){1'b0}}, s.cmpa};
            OFS_CMPP:   next_s.rdata = {{(32-CMPP_W){1'b0}}, s.cmpp};
            OFS_COUNT:  next_s.rdata = {{(32-CNT_W){1'b0}}, s.cnt};
            OFS_STATUS: next_s.rdata = {30'h00000000, s.flag_p, s.flag_a};
            default:
            begin
               next_s.rdata = '0;
               next_s.rresp = RESP_SLVERR;
            end
         endcase
      end

      next_s.aw_rdy = !next_s.aw_got && !next_s.bvalid;
      next_s.w_rdy  = !next_s.w_got && !next_s.bvalid;
      next_s.ar_rdy = !next_s.rvalid;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s          <= '0;
         s.ctrl     <= CTRL_RST;
         s.pin_oe_n <= 1'b1;
      end
      else
         s <= next_s;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign s_axi_awready     = s.aw_rdy;
   assign s_axi_wready      = s.w_rdy;
   assign s_axi_bvalid      = s.bvalid;
   assign s_axi_bresp       = s.bresp;
   assign s_axi_arready     = s.ar_rdy;
   assign s_axi_rvalid      = s.rvalid;
   assign s_axi_rdata       = s.rdata;
   assign s_axi_rresp       = s.rresp;
   assign timer_io_pin_out  = s.pin_out;
   assign timer_io_pin_oe_n = s.pin_oe_n;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_swap_period_clear: assert property (
      is_pwm && s.ctrl[B_SWAP] && s.ctrl[B_RUN] && !run_rise && tick &&
      a_hit |=> s.cnt == CNT_ZERO && s.flag_a)
      else $error("swapped PWM did not clear on compare A");

   a_pwm_p_clear: assert property (
      is_pwm && !s.ctrl[B_SWAP] && s.ctrl[B_RUN] && !run_rise && tick &&
      p_hit && !a_hit |=> s.cnt == CNT_ZERO && s.flag_p)
      else $error("PWM did not clear on compare P");

   a_forced_still_counts: assert property (
      is_pwm && pio == PIO_INACT && s.ctrl[B_RUN] && !run_rise && tick &&
      !p_hit && !a_hit && !do_wr
      |=> s.cnt == $past(s.cnt) + CNT_ONE ##1 s.pin_out == !act_lvl)
      else $error("forced PWM stopped counting or wrong level");

   a_pulse_a_stop: assert property (
      is_pulse && s.ctrl[B_RUN] && !run_rise && tick && a_hit && !do_wr
      |=> !s.ctrl[B_RUN] && s.flag_a ##1 s.pin_out == !act_lvl)
      else $error("single pulse not ended by compare A");

   a_ext_trigger: assert property (
      is_pulse && ext_edge && !do_wr |=> s.ctrl[B_RUN])
      else $error("external edge did not start pulse");

   a_run_rise_zero: assert property (
      run_rise |=> s.cnt == CNT_ZERO)
      else $error("run rising did not zero counter");

   a_capture_copy: assert property (
      is_cap && cap_edge |=> s.cmpa == $past(s.cnt) && s.flag_a)
      else $error("capture did not copy counter");

   a_capture_off: assert property (
      is_cap && pio == CAP_OFF && !do_wr |=> $stable(s.cmpa))
      else $error("capture happened while disabled");

   a_capture_no_drive: assert property (
      is_cap ##1 is_cap |-> s.pin_oe_n)
      else $error("pin driven in capture mode");

   c_pwm_wrap:    cover property (is_pwm && s.ctrl[B_RUN] && tick && p_hit);
   c_pulse_end:   cover property (is_pulse && s.ctrl[B_RUN] && tick && a_hit);
   c_ext_start:   cover property (is_pulse && ext_edge);
   c_capture_hit: cover property (is_cap && cap_edge);

endmodule

// >>> tb/test_timer_pwm_pulse_capture.sv
`timescale 1ns/1ps
module test_timer_pwm_pulse_capture;
   import tpc_pkg::*;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
   logic        bready, arvalid, arready, rvalid, rready, ext_pin;
   logic        pin_in, pin_out, pin_oe_n, win_en;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d, c;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   int          n_fail, total_checks, hi_cnt;

   tpc_timer i_dut
   (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ext_clock_pin(ext_pin), .timer_io_pin_in(pin_in),
      .timer_io_pin_out(pin_out), .timer_io_pin_oe_n(pin_oe_n)
   );

   tpc_pin_partner i_pin
   (
      .aclk(aclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .ext_clock_pin(ext_pin), .pin_in(pin_in)
   );

   always #25 aclk = ~aclk;

   // Count cycles with the pin high inside a measuring window
   always @(negedge aclk)
      if (win_en && pin_out === 1'b1)
         hi_cnt++;

   task automatic chk(input logic [31:0] got, exp, input string m);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      int n = 0;
      @(posedge aclk);
      awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
      bready <= 1'b1;
      while (1)
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1)
         begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
         if (++n > 200) begin chk(0, 1, "write hang"); break; end
      end
   endtask

   task automatic axr(input logic [7:0] a);
      int n = 0;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      while (1)
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1)
         begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
         if (++n > 200) begin chk(0, 1, "read hang"); break; end
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      axw(a, v);
      chk(r, RESP_OKAY, "write response");
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      axr(a);
      chk(d, e, "read data");
      chk(r, RESP_OKAY, "read response");
   endtask

   function automatic logic [31:0] cw(input logic run, input logic [1:0] md,
      input logic [1:0] pio, input logic inv, cl, sw);
      cw = 32'(run) | (32'(md) << B_MODE) | (32'(pio) << B_PIO)
         | (32'h1 << B_OC) | (32'(inv) << B_INV) | (32'(cl) << B_CCLR)
         | (32'(sw) << B_SWAP);
   endfunction

   // Active cycles expected in a window of whole periods
   function automatic int pwm_exp(input logic [15:0] a, input logic [7:0] p,
      input logic sw, input logic [1:0] pio, input int win);
      int per, dut;
      per = sw ? (a == 0 ? 65536 : int'(a)) : (p == 0 ? 65536 : p * 256);
      dut = sw ? (p == 0 ? 65536 : int'(p) * 256) : int'(a);
      if (pio == PIO_ACT || (pio == PIO_PWM && dut >= per)) return win;
      if (pio != PIO_PWM) return 0;
      return win / per * dut;
   endfunction

   task automatic pwm_row(input logic sw, input logic [1:0] pio,
      input logic inv, cl, input logic [15:0] a, input logic [7:0] p,
      input int win);
      int e;
      wr(OFS_CMPA, 32'(a));
      wr(OFS_CMPP, 32'(p));
      wr(OFS_CTRL, cw(0, MODE_PWM, pio, inv, cl, sw));
      wr(OFS_STATUS, 32'h3);
      wr(OFS_CTRL, cw(1, MODE_PWM, pio, inv, cl, sw));
      repeat (20) @(posedge aclk);
      hi_cnt = 0;
      win_en <= 1'b1;
      repeat (win) @(posedge aclk);
      win_en <= 1'b0;
      e = pwm_exp(a, p, sw, pio, win);
      chk(hi_cnt, inv ? win - e : e, "pwm high cycles");
      chk(pin_oe_n, 1'b0, "pwm drives pin");
      axr(OFS_STATUS);
      chk(d != 0, 1'b1, "pwm flags while running");
   endtask

   task automatic edge_chk(input logic lvl, input logic exp);
      wr(OFS_STATUS, 32'h3);
      i_pin.drive_pin(lvl);
      repeat (8) @(posedge aclk);
      axr(OFS_STATUS);
      chk(d[ST_A], exp, "capture flag");
   endtask

   // Watchdog, well beyond the expected run length
   initial
   begin
      #(50 * 40000);
      chk(0, 1, "watchdog expired");
      test_done();
   end

   initial
   begin
      aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0;
      arvalid = 0; rready = 0; awaddr = 0; araddr = 0; wdata = 0;
      wstrb = 4'hF; win_en = 0; hi_cnt = 0; n_fail = 0; total_checks = 0;
      void'($urandom(32'hADCC015C));
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(pin_oe_n, 1'b1, "pin released after reset");
      for (int i = 0; i < 5; i++) rd_chk(8'(i * 4), 32'h0);
      axr(8'h20);
      chk(r, RESP_SLVERR, "unmapped read");
      axw(8'h24, 32'hFFFF_FFFF);
      chk(r, RESP_SLVERR, "unmapped write");
      c = $urandom();
      wr(OFS_CMPA, c);
      rd_chk(OFS_CMPA, {16'h0, c[15:0]});
      wr(OFS_CMPP, c);
      rd_chk(OFS_CMPP, {24'h0, c[7:0]});
      $display("test registers done");

      wr(OFS_CMPP, 32'h0);
      wr(OFS_CTRL, cw(1, MODE_CAP, CAP_RISE, 0, 0, 0));
      chk(pin_oe_n, 1'b1, "capture drives nothing");
      for (int k = 0; k < 4; k++)
      begin
         wr(OFS_CTRL, cw(1, MODE_CAP, 2'(k), 1, 1, 1));
         edge_chk(1'b1, k == 0 || k == 2);
         edge_chk(1'b0, k == 1 || k == 2);
      end
      axr(OFS_COUNT);
      c = d;
      axr(OFS_COUNT);
      chk(d > c, 1'b1, "counter keeps running");
      wr(OFS_CTRL, cw(1, MODE_CAP, CAP_RISE, 0, 0, 0));
      edge_chk(1'b1, 1'b1);
      axr(OFS_CMPA);
      c = d;
      axr(OFS_COUNT);
      chk(c < d && c > 0, 1'b1, "captured count");
      wr(OFS_CMPP, 32'h1);
      wr(OFS_CTRL, cw(0, MODE_CAP, CAP_OFF, 0, 0, 0));
      wr(OFS_CTRL, cw(1, MODE_CAP, CAP_OFF, 0, 0, 0));
      repeat (300) @(posedge aclk);
      axr(OFS_STATUS);
      chk(d[ST_P], 1'b1, "compare p flag");
      axr(OFS_COUNT);
      chk(d < 256, 1'b1, "count limited");
      $display("test capture done");

      c = $urandom_range(255, 1);
      pwm_row(0, PIO_PWM, 0, 0, c[15:0], 8'h1, 512);
      pwm_row(0, PIO_PWM, 1, 0, 16'd64, 8'h1, 512);
      pwm_row(0, PIO_PWM, 0, 1, 16'd64, 8'h1, 512);
      pwm_row(1, PIO_PWM, 0, 0, 16'd300, 8'h1, 600);
      pwm_row(1, PIO_PWM, 0, 0, 16'd300, 8'h2, 600);
      pwm_row(1, PIO_PWM, 0, 0, 16'd300, 8'h0, 600);
      pwm_row(0, PIO_ACT, 0, 0, 16'd64, 8'h1, 512);
      pwm_row(0, PIO_INACT, 0, 0, 16'd64, 8'h1, 512);
      $display("test pwm done");

      wr(OFS_CTRL, cw(0, MODE_PWM, PIO_PULSE, 0, 0, 0));
      wr(OFS_CMPA, 32'd40);
      for (int k = 0; k < 2; k++)
      begin
         wr(OFS_STATUS, 32'h3);
         hi_cnt = 0;
         win_en <= 1'b1;
         if (k == 0) wr(OFS_CTRL, cw(1, MODE_PWM, PIO_PULSE, 0, 0, 0));
         else i_pin.ext_pulse();
         repeat (120) @(posedge aclk);
         win_en <= 1'b0;
         // Zeroing cycle of the run rise, then one per compare A count
         chk(hi_cnt, 41, "pulse width");
         rd_chk(OFS_CTRL, cw(0, MODE_PWM, PIO_PULSE, 0, 0, 0));
         rd_chk(OFS_STATUS, 32'h1);
      end
      wr(OFS_CMPA, 32'h0);
      hi_cnt = 0;
      win_en <= 1'b1;
      wr(OFS_CTRL, cw(1, MODE_PWM, PIO_PULSE, 0, 0, 0));
      repeat (30) @(posedge aclk);
      wr(OFS_CTRL, cw(0, MODE_PWM, PIO_PULSE, 0, 0, 0));
      repeat (5) @(posedge aclk);
      win_en <= 1'b0;
      chk(pin_out, 1'b0, "pulse ended by software");
      chk(hi_cnt > 30 && hi_cnt < 60, 1'b1, "pulse length");
      $display("test single pulse done");
      wr(OFS_CTRL, cw(0, MODE_CAP, CAP_OFF, 0, 0, 0));
      @(posedge aclk);
      chk(pin_oe_n, 1'b1, "capture releases pin");
      wr(OFS_CMPA, 32'd50);
      wr(OFS_STATUS, 32'h3);
      wr(OFS_CTRL, cw(1, MODE_TMR, PIO_INACT, 0, 1, 0));
      repeat (120) @(posedge aclk);
      rd_chk(OFS_STATUS, 32'h1);
      $display("test timer mode done");
      test_done();
   end
endmodule

// >>> tb/tpc_pin_partner.sv
`timescale 1ns/1ps
module tpc_pin_partner
(
   // Clock
   input  wire logic aclk,
   // Pins from the timer
   input  wire logic pin_out,
   input  wire logic pin_oe_n,
   // Pins towards the timer
   output logic      ext_clock_pin,
   output logic      pin_in
);
   logic src_lvl;

   initial
   begin
      src_lvl = 1'b0;
      ext_clock_pin = 1'b0;
   end

   // Shared wire: the timer wins while it drives, else the source
   assign pin_in = pin_oe_n ? src_lvl : pin_out;

   task automatic drive_pin(input logic v);
      @(posedge aclk);
      src_lvl <= v;
   endtask

   // Trigger edge, held long enough for the input synchroniser
   task automatic ext_pulse();
      @(posedge aclk);
      ext_clock_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      ext_clock_pin <= 1'b0;
   endtask
endmodule
